// ---- verilog/trp_consts.svh ----
// Constant values for the reload / PWM / capture timer
`ifndef TRP_CONSTS_SVH
`define TRP_CONSTS_SVH
`define TRP_CNT_W 16
`define TRP_PRE_W 7
`define TRP_DT_W 3
`define TRP_COUNT_RST 16'h0000
`define TRP_RESTART_VAL 16'h0001
`define TRP_PRE_RST 7'h00
`define TRP_DT_RST 3'h0
`endif

// ---- verilog/trp_pkg.sv ----
// Types for the reload / PWM / capture timer
package trp_pkg;
  typedef enum logic [2:0]
  {
    trp_one_shot,
    trp_continuous,
    trp_capture_compare,
    trp_pwm_dual,
    trp_capture_restart,
    trp_comparator_counter
  } trp_mode_t;
endpackage

// ---- verilog/trp_timer.sv ----
// 16-bit reload timer with PWM, capture and prescaler
// What this block does
// - Continuous mode counts up to reload value.
// - At reload: interrupt, load 0001H, keep counting.
// - Continuous reload inverts timer output level.
// - Software start count applies first pass only.
// - One-shot/continuous clock only from prescaler.
// - One-shot lasts (reload minus start) times prescale.
// - Later continuous passes last reload times prescale.
// - Nonstandard first start lasts (reload minus start plus one) times prescale.
// - Capture/compare starts on edge, captures later edges.
// - PWM polarity 0 output levels and switching.
// - PWM polarity 1 output levels, reversed.
// - PWM waits dead-time before driving active level.
// - Capture-restart captures count on selected edge.
// - Comparator counter: disabled level, toggle at reload.
// - Pin function shows polarity even while disabled.
// - Polarity change while running not seen immediately.
// - Prescaler divides by two to select power.
// - Prescaler clears whenever timer is disabled.
`timescale 1ns/10ps
`include "trp_consts.svh"

module trp_timer
  import trp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration
  input wire logic timer_enable,
  input trp_mode_t timer_mode,
  input wire logic output_polarity_bit,
  input wire logic [2:0] prescale_select,
  input wire logic [`TRP_DT_W-1:0] pwm_deadtime_delay,
  input wire logic output_function_enable,
  input wire logic [`TRP_CNT_W-1:0] reload_value,
  input wire logic [`TRP_CNT_W-1:0] pwm_value,
  // Software count load
  input wire logic count_write,
  input wire logic [`TRP_CNT_W-1:0] count_wdata,
  // Timer input pin
  input wire logic timer_input_pin,
  // Status
  output logic [`TRP_CNT_W-1:0] count,
  output logic [`TRP_CNT_W-1:0] capture_value,
  output logic capture_strobe,
  output logic timer_irq,
  // Timer output pins
  output logic timer_output_pin,
  output logic timer_output_comp,
  output logic timer_output_oe
);

  // ****************************************************
  // Input synchroniser and prescaler
  // ****************************************************
  logic in_meta, in_sync, in_prev;
  logic next_in_meta, next_in_sync, next_in_prev;
  logic [`TRP_PRE_W-1:0] pre_cnt, next_pre_cnt;
  logic tick;
  logic act_edge;

  function automatic logic [`TRP_PRE_W-1:0] pre_mask(
    input logic [2:0] sel);
    logic [`TRP_PRE_W-1:0] m;
    m = `TRP_PRE_RST;
    for (int i = 0; i < `TRP_PRE_W; i++)
    begin
      if (i < int'(sel))
        m[i] = 1'b1;
    end
    return m;
  endfunction

  always_comb
  begin
    next_in_meta = timer_input_pin;
    next_in_sync = in_meta;
    next_in_prev = in_sync;
    // Held at zero while disabled so each restart divides cleanly
    if (!timer_enable)
      next_pre_cnt = `TRP_PRE_RST;
    else
      next_pre_cnt = pre_cnt + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
      in_prev <= 1'b0;
      pre_cnt <= `TRP_PRE_RST;
    end
    else
    begin
      in_meta <= next_in_meta;
      in_sync <= next_in_sync;
      in_prev <= next_in_prev;
      pre_cnt <= next_pre_cnt;
    end
  end

  // One tick per 2^select system clocks
  assign tick = timer_enable &&
    ((pre_cnt & pre_mask(prescale_select)) ==
     pre_mask(prescale_select));

  // ****************************************************
  // Counter, capture and outputs
  // ****************************************************
  logic run_pol, next_run_pol;
  logic done, next_done;
  logic started, next_started;
  logic dt_wait, next_dt_wait;
  logic dt_for_out, next_dt_for_out;
  logic [`TRP_DT_W-1:0] dt_cnt, next_dt_cnt;
  logic [`TRP_CNT_W-1:0] next_count, next_capture_value;
  logic next_capture_strobe, next_timer_irq;
  logic next_out, next_comp, next_oe;
  logic step, at_reload;

  // Polarity is frozen while running: a write only lands on the
  // next disable, so the pin never glitches mid-period
  assign act_edge = run_pol ? (in_prev & ~in_sync)
                            : (in_sync & ~in_prev);

  always_comb
  begin
    next_run_pol = timer_enable ? run_pol
                                : output_polarity_bit;
    next_done = done;
    next_started = started;
    next_dt_wait = dt_wait;
    next_dt_for_out = dt_for_out;
    next_dt_cnt = dt_cnt;
    next_count = count;
    next_capture_value = capture_value;
    next_capture_strobe = 1'b0;
    next_timer_irq = 1'b0;
    next_out = timer_output_pin;
    next_comp = timer_output_comp;
    next_oe = output_function_enable;
    step = 1'b0;
    at_reload = 1'b0;
    if (!timer_enable)
    begin
      next_done = 1'b0;
      next_started = 1'b0;
      next_dt_wait = 1'b0;
      next_out = output_polarity_bit;
      next_comp = ~output_polarity_bit;
    end
    else
    begin
      case (timer_mode)
        trp_one_shot, trp_continuous, trp_pwm_dual:
          step = tick && !done;
        trp_capture_compare:
          step = tick && started;
        trp_capture_restart:
          step = tick;
        trp_comparator_counter:
          step = act_edge;
        default:
          step = 1'b0;
      endcase
      if (timer_mode == trp_capture_compare && act_edge)
      begin
        next_started = 1'b1;
        if (started)
        begin
          next_capture_value = count;
          next_capture_strobe = 1'b1;
        end
      end
      if (step)
      begin
        if (timer_mode == trp_one_shot)
        begin
          // Stops with the count at reload
          next_count = count + 1'b1;
          if (next_count == reload_value)
          begin
            next_timer_irq = 1'b1;
            next_done = 1'b1;
            next_out = ~timer_output_pin;
          end
        end
        else if (count == reload_value)
        begin
          at_reload = 1'b1;
          next_timer_irq = 1'b1;
          next_count = `TRP_RESTART_VAL;
          if (timer_mode != trp_pwm_dual)
            next_out = ~timer_output_pin;
        end
        else
          next_count = count + 1'b1;
      end
      if (timer_mode == trp_capture_restart && act_edge)
      begin
        next_capture_value = count;
        next_capture_strobe = 1'b1;
        next_count = `TRP_RESTART_VAL;
      end
      if (timer_mode == trp_pwm_dual)
      begin
        if (dt_wait)
        begin
          next_dt_cnt = dt_cnt - 1'b1;
          if (dt_cnt == `TRP_DT_W'(1))
          begin
            next_dt_wait = 1'b0;
            if (dt_for_out)
              next_out = ~run_pol;
            else
              next_comp = ~run_pol;
          end
        end
        if (at_reload)
        begin
          // Output back to idle at once, complement after dead time
          next_out = run_pol;
          next_dt_for_out = 1'b0;
          next_dt_cnt = pwm_deadtime_delay;
          next_dt_wait = (pwm_deadtime_delay != `TRP_DT_RST);
          if (pwm_deadtime_delay == `TRP_DT_RST)
            next_comp = ~run_pol;
        end
        else if (step && count == pwm_value)
        begin
          next_comp = run_pol;
          next_dt_for_out = 1'b1;
          next_dt_cnt = pwm_deadtime_delay;
          next_dt_wait = (pwm_deadtime_delay != `TRP_DT_RST);
          if (pwm_deadtime_delay == `TRP_DT_RST)
            next_out = ~run_pol;
        end
      end
      else
      begin
        next_dt_wait = 1'b0;
        next_comp = ~next_out;
      end
    end
    // A software write always wins over the counter
    if (count_write)
      next_count = count_wdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      run_pol <= 1'b0;
      done <= 1'b0;
      started <= 1'b0;
      dt_wait <= 1'b0;
      dt_for_out <= 1'b0;
      dt_cnt <= `TRP_DT_RST;
      count <= `TRP_COUNT_RST;
      capture_value <= `TRP_COUNT_RST;
      capture_strobe <= 1'b0;
      timer_irq <= 1'b0;
      timer_output_pin <= 1'b0;
      timer_output_comp <= 1'b1;
      timer_output_oe <= 1'b0;
    end
    else
    begin
      run_pol <= next_run_pol;
      done <= next_done;
      started <= next_started;
      dt_wait <= next_dt_wait;
      dt_for_out <= next_dt_for_out;
      dt_cnt <= next_dt_cnt;
      count <= next_count;
      capture_value <= next_capture_value;
      capture_strobe <= next_capture_strobe;
      timer_irq <= next_timer_irq;
      timer_output_pin <= next_out;
      timer_output_comp <= next_comp;
      timer_output_oe <= next_oe;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_prescale_clear: assert property (@(posedge ref_clk) disable iff (rst)
    !timer_enable |=> pre_cnt == `TRP_PRE_RST)
    else $error("prescaler not cleared while disabled");

  a_cont_reload: assert property (@(posedge ref_clk) disable iff (rst)
    (timer_mode == trp_continuous && step && count == reload_value
     && !count_write) |=> (count == `TRP_RESTART_VAL && timer_irq))
    else $error("continuous reload did not restart at one");

  a_cont_toggle: assert property (@(posedge ref_clk) disable iff (rst)
    (timer_mode == trp_continuous && at_reload)
    |=> timer_output_pin != $past(timer_output_pin))
    else $error("output did not toggle at reload");

  a_pin_clock: assert property (@(posedge ref_clk) disable iff (rst)
    (timer_enable && timer_mode == trp_continuous && !count_write
     && !tick) |=> $stable(count))
    else $error("count moved without a prescaler tick");

  a_oneshot_stop: assert property (@(posedge ref_clk) disable iff (rst)
    (timer_irq && $past(timer_mode) == trp_one_shot && timer_enable
     && timer_mode == trp_one_shot && !count_write)
    |=> $stable(count))
    else $error("one-shot kept counting after time-out");

  a_idle_level: assert property (@(posedge ref_clk) disable iff (rst)
    !timer_enable |=> (timer_output_pin == $past(output_polarity_bit)
    && timer_output_comp == !$past(output_polarity_bit)))
    else $error("disabled output not at polarity level");

  a_pol_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    (timer_enable && $past(timer_enable)) |-> $stable(run_pol))
    else $error("running polarity changed");

  a_pwm_match: assert property (@(posedge ref_clk) disable iff (rst)
    (timer_mode == trp_pwm_dual && step && count == pwm_value
     && count != reload_value && !dt_wait)
    |=> timer_output_comp == run_pol)
    else $error("complement not idle after match");

  a_deadtime: assert property (@(posedge ref_clk) disable iff (rst)
    (timer_mode == trp_pwm_dual && timer_enable && at_reload
     && timer_output_comp == run_pol
     && pwm_deadtime_delay == `TRP_DT_W'(2))
    |=> (timer_output_comp == run_pol) ##1
        (timer_output_comp == run_pol))
    else $error("complement switched before dead time");

  a_capture_edge: assert property (@(posedge ref_clk) disable iff (rst)
    (timer_enable && timer_mode == trp_capture_restart && act_edge)
    |=> (capture_strobe && capture_value == $past(count)))
    else $error("capture missed on selected edge");

endmodule

// ---- bench/trp_pin_model.sv ----
// Far-side source for the timer input pin
`timescale 1ns/10ps
module trp_pin_model
(
  // Clock
  input wire logic ref_clk,
  // Control
  input wire logic run,
  input wire logic [7:0] half_period,
  // Pin
  output logic pin = 1'b0
);
  logic [7:0] cnt = 8'h00;
  // Pin holds its last level when stopped, like a driven source
  always @(posedge ref_clk)
  begin
    if (!run)
      cnt <= 8'h00;
    else if (cnt == half_period - 8'h01)
    begin
      cnt <= 8'h00;
      // Late change keeps the edge off the sampling instant
      pin <= #3 ~pin;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule

// ---- bench/test_trp_timer.sv ----
// Self-checking bench for the reload / PWM / capture timer
`timescale 1ns/10ps
module test_trp_timer
  import trp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic timer_enable = 1'b0;
  trp_mode_t timer_mode = trp_one_shot;
  logic output_polarity_bit = 1'b0;
  logic [2:0] prescale_select = 3'h0;
  logic [2:0] pwm_deadtime_delay = 3'h2;
  logic output_function_enable = 1'b0;
  logic [15:0] reload_value = 16'h0000;
  logic [15:0] pwm_value = 16'h0002;
  logic count_write = 1'b0;
  logic [15:0] count_wdata = 16'h0000;
  logic timer_input_pin, pin_run = 1'b0;
  logic [15:0] count, capture_value;
  logic capture_strobe, timer_irq, timer_output_pin;
  logic timer_output_comp, timer_output_oe, prev_out = 1'b0;
  logic prev_en = 1'b0;
  logic exp_out;
  logic [15:0] last_val = 16'h0000;
  logic [15:0] cap_span;
  integer seed = 70299, err_total = 0, n_checks = 0, cyc = 0;
  integer last_irq = 0, last_cap = 0, cap_gap = 0, i, r, s;
  int q_gap[$];
  logic [15:0] q_cnt[$];

  trp_timer u_trp_timer
  (
    .ref_clk, .rst, .timer_enable, .timer_mode, .output_polarity_bit,
    .prescale_select, .pwm_deadtime_delay, .output_function_enable,
    .reload_value, .pwm_value, .count_write, .count_wdata,
    .timer_input_pin, .count, .capture_value, .capture_strobe,
    .timer_irq, .timer_output_pin, .timer_output_comp, .timer_output_oe
  );

  trp_pin_model u_trp_pin_model
  (
    .ref_clk,
    .run(pin_run),
    .half_period(8'h05),
    .pin(timer_input_pin)
  );

  always #12.5 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task give_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    // First time-out is timed from the edge that first sees the enable
    if (timer_enable === 1'b1 && prev_en === 1'b0)
      last_irq = cyc;
    if (timer_irq === 1'b1)
    begin
      if (q_cnt.size() == 0)
        chk("spare irq", 0, 1);
      else
      begin
        if (q_gap[0] != 0)
          chk("irq gap", q_gap[0], cyc - last_irq);
        chk("irq count", q_cnt[0], count);
        // PWM returns to the polarity level at reload, others toggle
        exp_out = !prev_out;
        if (timer_mode == trp_pwm_dual)
          exp_out = output_polarity_bit;
        chk("out level", exp_out, timer_output_pin);
        q_gap.delete(0);
        q_cnt.delete(0);
      end
      last_irq = cyc;
    end
    if (capture_strobe === 1'b1 && cap_gap != 0)
    begin
      if (last_cap != 0)
      begin
        chk("cap gap", cap_gap, cyc - last_cap);
        // Restart mode captures ticks since the last edge
        cap_span = capture_value - last_val;
        if (timer_mode == trp_capture_restart)
          cap_span = capture_value;
        chk("cap value", cap_gap, cap_span);
      end
      last_cap = cyc;
      last_val = capture_value;
    end
    prev_out = timer_output_pin;
    prev_en = timer_enable;
  end

  // Configure while disabled, load the start count, then enable
  task automatic run(input trp_mode_t m, input int rl, st, sel, n);
    int k;
    int g;
    timer_enable <= 1'b0;
    timer_mode <= m;
    prescale_select <= sel[2:0];
    reload_value <= rl[15:0];
    count_write <= 1'b1;
    count_wdata <= st[15:0];
    @(posedge ref_clk);
    count_write <= 1'b0;
    @(posedge ref_clk);
    chk("load", st[15:0], count);
    g = (rl - st + 1) << sel;
    if (m == trp_one_shot)
      g = (rl - st) << sel;
    // Pin phase makes the first comparator pass untimed
    if (m == trp_comparator_counter)
      g = 0;
    q_gap.push_back(g);
    q_cnt.push_back(m == trp_one_shot ? rl[15:0] : 16'h0001);
    // Pin model gives one active edge every ten clocks
    g = (m == trp_comparator_counter) ? rl * 10 : rl << sel;
    for (k = 1; k < n; k++)
    begin
      q_gap.push_back(g);
      q_cnt.push_back(16'h0001);
    end
    timer_enable <= 1'b1;
    for (k = 0; k < 400 && q_cnt.size() != 0; k++)
      @(posedge ref_clk);
    chk("irq wait", 0, q_cnt.size());
    if (q_cnt.size() != 0)
      give_verdict;
    // One-shot must stay silent after its time-out
    if (m == trp_one_shot)
      repeat (40) @(posedge ref_clk);
    timer_enable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge ref_clk);
    chk("rst count", 16'h0000, count);
    chk("rst comp", 1, timer_output_comp);
    chk("rst oe", 0, timer_output_oe);
    rst <= 1'b0;
    output_function_enable <= 1'b1;
    // Pin keeps toggling so clock-only modes must ignore it
    pin_run <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      r = 3 + $unsigned($random(seed)) % 7;
      s = 1 + $unsigned($random(seed)) % (r - 1);
      output_polarity_bit <= i[0];
      run(trp_continuous, r, s, $unsigned($random(seed)) % 3, 3);
      run(trp_one_shot, r, s, 1, 1);
      run(trp_pwm_dual, r, s, $unsigned($random(seed)) % 3, 3);
      run(trp_comparator_counter, r, s, 0, 2);
    end
    pin_run <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      timer_mode <= i[1] ? trp_pwm_dual : trp_comparator_counter;
      output_polarity_bit <= i[0];
      repeat (3) @(posedge ref_clk);
      chk("idle out", i[0], timer_output_pin);
      chk("oe", 1, timer_output_oe);
      if (i[1])
        chk("idle comp", !i[0], timer_output_comp);
    end
    timer_mode <= trp_comparator_counter;
    timer_enable <= 1'b1;
    @(posedge ref_clk);
    output_polarity_bit <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("pol hold", 1, timer_output_pin);
    for (i = 0; i < 2; i++)
    begin
      timer_enable <= 1'b0;
      timer_mode <= i[0] ? trp_capture_compare : trp_capture_restart;
      output_polarity_bit <= i[0];
      prescale_select <= 3'h0;
      reload_value <= 16'hFFFF;
      pin_run <= 1'b1;
      last_cap = 0;
      cap_gap = 10;
      @(posedge ref_clk);
      timer_enable <= 1'b1;
      repeat (60) @(posedge ref_clk);
      chk("cap seen", 1, last_cap != 0);
      timer_enable <= 1'b0;
      pin_run <= 1'b0;
      @(posedge ref_clk);
      cap_gap = 0;
    end
    give_verdict;
  end
endmodule
